// ---- usl_pkg.sv ----
// constants, types and register map of the serial status and line control block
package usl_pkg;

  localparam logic [2:0] ADDR_STATUS = 3'h0;
  localparam logic [2:0] ADDR_CTRL_ONE = 3'h1;
  localparam logic [2:0] ADDR_CTRL_TWO = 3'h2;
  localparam logic [2:0] ADDR_CTRL_THREE = 3'h3;
  localparam logic [2:0] ADDR_DATA = 3'h4;
  localparam logic [2:0] ADDR_BAUD_HI = 3'h5;
  localparam logic [2:0] ADDR_BAUD_LO = 3'h6;
  localparam logic [2:0] ADDR_RX_COUNT = 3'h7;

  localparam logic [7:0] STATUS_RESET = 8'h0b;
  localparam logic [15:0] BAUD_DIV_RESET = 16'h0000;
  localparam logic [15:0] BAUD_DIV_MIN = 16'h0010;
  localparam logic [3:0] TX_STOP_BITS = 4'h2;
  localparam logic [3:0] BREAK_BITS = 4'hd;
  localparam logic [2:0] RX_FIFO_DEPTH = 3'h4;
  localparam logic [3:0] BITS_SHORT = 4'h8;
  localparam logic [3:0] BITS_LONG = 4'h9;

  localparam int ENTRY_PARITY_ERROR_FLAG = 11;
  localparam int ENTRY_NF = 10;
  localparam int ENTRY_FRAMING_ERROR_FLAG = 9;

  localparam logic [1:0] PAR_EVEN = 2'h0;
  localparam logic [1:0] PAR_ODD = 2'h1;
  localparam logic [1:0] PAR_MARK = 2'h2;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b11,
    RX_STOP = 2'b10
  } usl_rx_state_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b011,
    TX_STOP = 3'b010,
    TX_BREAK = 3'b110
  } usl_tx_state_t;

endpackage : usl_pkg

// ---- usl_core.sv ----
// serial transceiver with status flags, line control and register port
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module usl_core
  import usl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic tx_out,
  output logic tx_oe,
  input wire logic rxtx_in,
  output logic rxtx_out,
  output logic rxtx_oe,
  output logic rx_irq
);

  typedef struct packed {
    logic global_enable;
    logic data_length_select;
    logic parity_enable;
    logic [1:0] parity_type;
    logic break_request;
    logic transmit_ninth_bit;
    logic transmitter_enable;
    logic receiver_enable;
    logic receiver_stop_count;
    logic receiver_interrupt_enable;
    logic single_wire_select;
    logic [15:0] baud_div;
    logic parity_error_flag;
    logic noise_flag;
    logic framing_error_flag;
    logic overrun_flag;
    logic receive_available_flag;
    logic transmitter_idle_flag;
    logic transmit_empty_flag;
    logic arm_err;
    logic arm_rxav;
    logic arm_transmitter_idle_flag;
    logic arm_tempty;
    logic [3:0][11:0] fifo;
    logic [1:0] rd_ptr;
    logic [2:0] count;
    logic [7:0] rdata;
    logic [8:0] tx_buf;
    logic tx_full;
    usl_tx_state_t tx_state;
    logic [15:0] tx_cnt;
    logic [3:0] tx_bit;
    logic [8:0] tx_shift;
    logic tx_line;
    usl_rx_state_t rx_state;
    logic [15:0] rx_cnt;
    logic [3:0] rx_bit;
    logic [8:0] rx_shift;
    logic rx_prev;
    logic rx_noise;
    logic rx_framing_error_flag;
  } usl_state_t;

  usl_state_t s;
  usl_state_t next_s;

  // parity value for the bit that replaces the top data bit
  function automatic logic par_bit(input logic [8:0] d, input logic long, input logic [1:0] ptype);
    logic [8:0] m;
    m = long ? {1'b0, d[7:0]} : {2'b00, d[6:0]};
    unique case (ptype)
      PAR_EVEN: par_bit = ^m;
      PAR_ODD: par_bit = ~(^m);
      PAR_MARK: par_bit = 1'b1;
      default: par_bit = 1'b0;
    endcase
  endfunction : par_bit

  function automatic logic [7:0] status_byte(input usl_state_t t);
    status_byte = {t.parity_error_flag, t.noise_flag, t.framing_error_flag, t.overrun_flag,
                   t.rx_state == RX_IDLE, t.receive_available_flag, t.transmitter_idle_flag,
                   t.transmit_empty_flag};
  endfunction : status_byte

  logic [15:0] bit_len;
  logic [15:0] half_len;
  logic [3:0] nbits;
  logic tx_run;
  logic rx_run;
  logic load_ev;
  logic push_ev;
  logic data_wr;
  logic data_rd;
  logic [8:0] word;
  logic [11:0] entry;
  logic [1:0] wr_ptr;

  // small divisors are clamped so the mid-bit sample point always exists
  assign bit_len = (s.baud_div < BAUD_DIV_MIN) ? BAUD_DIV_MIN : s.baud_div;
  assign half_len = {1'b0, bit_len[15:1]};
  assign nbits = s.data_length_select ? BITS_LONG : BITS_SHORT;
  assign tx_run = s.global_enable & s.transmitter_enable;
  assign rx_run = s.global_enable & s.receiver_enable;
  assign data_wr = wr & (addr == ADDR_DATA);
  assign data_rd = rd & (addr == ADDR_DATA);

  always_comb begin
    next_s = s;
    next_s.rdata = 8'h00;
    load_ev = 1'b0;
    push_ev = 1'b0;
    word = 9'h000;
    entry = 12'h000;
    wr_ptr = 2'h0;
    next_s.rx_prev = rxtx_in;

    // transmit engine
    if (!tx_run) begin
      next_s.tx_state = TX_IDLE;
      next_s.tx_full = 1'b0;
      next_s.tx_cnt = 16'h0000;
      next_s.tx_line = 1'b1;
    end else begin
      unique case (s.tx_state)
        TX_IDLE: begin
          next_s.tx_cnt = 16'h0000;
          next_s.tx_line = 1'b1;
          if (s.tx_full) begin
            word = {s.transmit_ninth_bit & s.data_length_select, s.tx_buf[7:0]};
            if (s.parity_enable && s.data_length_select) begin
              word[8] = par_bit(word, 1'b1, s.parity_type);
            end else if (s.parity_enable) begin
              word[7] = par_bit(word, 1'b0, s.parity_type);
            end
            next_s.tx_shift = word;
            next_s.tx_full = 1'b0;
            next_s.tx_state = TX_START;
            next_s.tx_line = 1'b0;
            load_ev = 1'b1;
          end else if (s.break_request) begin
            next_s.tx_state = TX_BREAK;
            next_s.tx_bit = 4'h0;
            next_s.tx_line = 1'b0;
          end
        end
        TX_START: begin
          next_s.tx_cnt = s.tx_cnt + 16'h0001;
          if (s.tx_cnt == bit_len - 16'h0001) begin
            next_s.tx_cnt = 16'h0000;
            next_s.tx_bit = 4'h0;
            next_s.tx_state = TX_DATA;
            next_s.tx_line = s.tx_shift[0];
          end
        end
        TX_DATA: begin
          next_s.tx_cnt = s.tx_cnt + 16'h0001;
          if (s.tx_cnt == bit_len - 16'h0001) begin
            next_s.tx_cnt = 16'h0000;
            next_s.tx_shift = {1'b0, s.tx_shift[8:1]};
            next_s.tx_bit = s.tx_bit + 4'h1;
            next_s.tx_line = s.tx_shift[1];
            if (s.tx_bit == nbits - 4'h1) begin
              next_s.tx_state = TX_STOP;
              next_s.tx_bit = 4'h0;
              next_s.tx_line = 1'b1;
            end
          end
        end
        TX_STOP: begin
          next_s.tx_cnt = s.tx_cnt + 16'h0001;
          if (s.tx_cnt == bit_len - 16'h0001) begin
            next_s.tx_cnt = 16'h0000;
            next_s.tx_bit = s.tx_bit + 4'h1;
            if (s.tx_bit == TX_STOP_BITS - 4'h1) begin
              next_s.tx_state = TX_IDLE;
            end
          end
        end
        TX_BREAK: begin
          next_s.tx_line = 1'b0;
          next_s.tx_cnt = s.tx_cnt + 16'h0001;
          if (s.tx_cnt == bit_len - 16'h0001) begin
            next_s.tx_cnt = 16'h0000;
            if (s.tx_bit != BREAK_BITS) begin
              next_s.tx_bit = s.tx_bit + 4'h1;
            end else if (!s.break_request) begin
              next_s.tx_state = TX_IDLE;
              next_s.tx_line = 1'b1;
            end
          end
        end
      endcase
    end

    // register port; status is never written
    if (rd) begin
      unique case (addr)
        ADDR_STATUS: begin
          next_s.rdata = status_byte(s);
          next_s.arm_err = s.parity_error_flag | s.noise_flag | s.framing_error_flag | s.overrun_flag;
          next_s.arm_rxav = s.receive_available_flag;
          next_s.arm_transmitter_idle_flag = s.transmitter_idle_flag;
          next_s.arm_tempty = s.transmit_empty_flag;
        end
        ADDR_CTRL_ONE: begin
          // transmit ninth bit reads zero
          next_s.rdata = {s.global_enable, s.data_length_select, s.parity_enable, s.parity_type,
                          s.break_request, s.fifo[s.rd_ptr][8] & (s.count != 3'h0), 1'b0};
        end
        ADDR_CTRL_TWO: begin
          next_s.rdata = {s.transmitter_enable, s.receiver_enable, s.receiver_stop_count, 2'b00,
                          s.receiver_interrupt_enable, 2'b00};
        end
        ADDR_CTRL_THREE: next_s.rdata = {7'h00, s.single_wire_select};
        ADDR_DATA: begin
          next_s.rdata = s.fifo[s.rd_ptr][7:0];
          if (s.count != 3'h0) begin
            next_s.rd_ptr = s.rd_ptr + 2'h1;
            next_s.count = s.count - 3'h1;
          end
          if (s.arm_err) begin
            next_s.parity_error_flag = 1'b0;
            next_s.noise_flag = 1'b0;
            next_s.framing_error_flag = 1'b0;
            next_s.overrun_flag = 1'b0;
          end
          if (s.arm_rxav && next_s.count == 3'h0) begin
            next_s.receive_available_flag = 1'b0;
          end
          next_s.arm_err = 1'b0;
          next_s.arm_rxav = 1'b0;
        end
        ADDR_BAUD_HI: next_s.rdata = s.baud_div[15:8];
        ADDR_BAUD_LO: next_s.rdata = s.baud_div[7:0];
        ADDR_RX_COUNT: next_s.rdata = {5'h00, s.count};
      endcase
    end

    if (wr) begin
      unique case (addr)
        ADDR_CTRL_ONE: begin
          next_s.global_enable = wdata[7];
          next_s.data_length_select = wdata[6];
          next_s.parity_enable = wdata[5];
          next_s.parity_type = wdata[4:3];
          next_s.break_request = wdata[2];
          next_s.transmit_ninth_bit = wdata[0];
        end
        ADDR_CTRL_TWO: begin
          next_s.transmitter_enable = wdata[7];
          next_s.receiver_enable = wdata[6];
          next_s.receiver_stop_count = wdata[5];
          next_s.receiver_interrupt_enable = wdata[2];
          if (wdata[7] && !s.transmitter_enable) begin
            next_s.transmit_empty_flag = 1'b1;
          end
        end
        ADDR_CTRL_THREE: next_s.single_wire_select = wdata[0];
        ADDR_DATA: begin
          if (tx_run) begin
            next_s.tx_buf = {1'b0, wdata};
            next_s.tx_full = 1'b1;
          end
          if (s.arm_tempty) begin
            next_s.transmit_empty_flag = 1'b0;
          end
          if (s.arm_transmitter_idle_flag) begin
            next_s.transmitter_idle_flag = 1'b0;
          end
          if (s.arm_err) begin
            next_s.parity_error_flag = 1'b0;
            next_s.noise_flag = 1'b0;
            next_s.framing_error_flag = 1'b0;
            next_s.overrun_flag = 1'b0;
          end
          next_s.arm_tempty = 1'b0;
          next_s.arm_transmitter_idle_flag = 1'b0;
          next_s.arm_err = 1'b0;
        end
        ADDR_BAUD_HI: next_s.baud_div[15:8] = wdata;
        ADDR_BAUD_LO: next_s.baud_div[7:0] = wdata;
        default: ;
      endcase
    end

    // hardware sets come after the software clears so a coincident event wins, except the idle set, which a data write blocks
    if (load_ev) begin
      next_s.transmit_empty_flag = 1'b1;
    end
    if (tx_run && s.tx_state == TX_IDLE && !s.tx_full && !s.break_request && !data_wr) begin
      next_s.transmitter_idle_flag = 1'b1;
    end

    // receive engine
    if (!rx_run) begin
      next_s.rx_state = RX_IDLE;
      next_s.rx_cnt = 16'h0000;
      next_s.count = 3'h0;
    end else begin
      unique case (s.rx_state)
        RX_IDLE: begin
          next_s.rx_cnt = 16'h0000;
          if (!rxtx_in) begin
            next_s.rx_state = RX_START;
            next_s.rx_noise = 1'b0;
            next_s.rx_framing_error_flag = 1'b0;
          end
        end
        RX_START: begin
          next_s.rx_cnt = s.rx_cnt + 16'h0001;
          if (s.rx_cnt == half_len) begin
            next_s.rx_cnt = 16'h0000;
            next_s.rx_bit = 4'h0;
            // a glitch shorter than half a bit is not a start
            next_s.rx_state = rxtx_in ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA: begin
          next_s.rx_cnt = s.rx_cnt + 16'h0001;
          if (s.rx_cnt == bit_len - 16'h0001) begin
            next_s.rx_cnt = 16'h0000;
            next_s.rx_shift = {rxtx_in, s.rx_shift[8:1]};
            next_s.rx_noise = s.rx_noise | (rxtx_in != s.rx_prev);
            next_s.rx_bit = s.rx_bit + 4'h1;
            if (s.rx_bit == nbits - 4'h1) begin
              next_s.rx_state = RX_STOP;
              next_s.rx_bit = 4'h0;
            end
          end
        end
        RX_STOP: begin
          next_s.rx_cnt = s.rx_cnt + 16'h0001;
          if (s.rx_cnt == bit_len - 16'h0001) begin
            next_s.rx_cnt = 16'h0000;
            next_s.rx_framing_error_flag = s.rx_framing_error_flag | !rxtx_in;
            next_s.rx_noise = s.rx_noise | (rxtx_in != s.rx_prev);
            if (s.receiver_stop_count && s.rx_bit == 4'h0) begin
              next_s.rx_bit = 4'h1;
            end else begin
              next_s.rx_state = RX_IDLE;
              push_ev = 1'b1;
            end
          end
        end
      endcase
    end

    if (push_ev) begin
      word = s.data_length_select ? s.rx_shift : {1'b0, s.rx_shift[8:1]};
      entry = {1'b0, next_s.rx_noise, next_s.rx_framing_error_flag, word};
      if (s.parity_enable && s.data_length_select) begin
        entry[ENTRY_PARITY_ERROR_FLAG] = word[8] != par_bit(word, 1'b1, s.parity_type);
        entry[8] = 1'b0;
      end else if (s.parity_enable) begin
        entry[ENTRY_PARITY_ERROR_FLAG] = word[7] != par_bit(word, 1'b0, s.parity_type);
        entry[7] = 1'b0;
      end
      wr_ptr = next_s.rd_ptr + next_s.count[1:0];
      if (s.overrun_flag) begin
        // word dropped while overrun stands
      end else if (next_s.count == RX_FIFO_DEPTH) begin
        next_s.overrun_flag = 1'b1;
      end else begin
        next_s.fifo[wr_ptr] = entry;
        next_s.count = next_s.count + 3'h1;
        next_s.receive_available_flag = 1'b1;
        next_s.parity_error_flag = next_s.parity_error_flag | entry[ENTRY_PARITY_ERROR_FLAG];
        next_s.noise_flag = next_s.noise_flag | entry[ENTRY_NF];
        next_s.framing_error_flag = next_s.framing_error_flag | entry[ENTRY_FRAMING_ERROR_FLAG];
      end
    end

    // disabled unit: configuration other than enables and break survives
    if (!next_s.global_enable) begin
      next_s.transmitter_enable = 1'b0;
      next_s.receiver_enable = 1'b0;
      next_s.break_request = 1'b0;
      next_s.receive_available_flag = 1'b0;
      next_s.overrun_flag = 1'b0;
      next_s.framing_error_flag = 1'b0;
      next_s.parity_error_flag = 1'b0;
      next_s.noise_flag = 1'b0;
      next_s.count = 3'h0;
      next_s.tx_full = 1'b0;
      next_s.transmitter_idle_flag = 1'b1;
      next_s.transmit_empty_flag = 1'b1;
      next_s.tx_state = TX_IDLE;
      next_s.rx_state = RX_IDLE;
      next_s.tx_cnt = 16'h0000;
      next_s.rx_cnt = 16'h0000;
      next_s.tx_line = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s <= '0;
      s.baud_div <= BAUD_DIV_RESET;
      s.receive_available_flag <= STATUS_RESET[2];
      s.transmitter_idle_flag <= STATUS_RESET[1];
      s.transmit_empty_flag <= STATUS_RESET[0];
      s.tx_state <= TX_IDLE;
      s.rx_state <= RX_IDLE;
      s.tx_line <= 1'b1;
      s.rx_prev <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign tx_out = s.tx_line;
  assign tx_oe = tx_run;
  assign rxtx_out = s.tx_line;
  // receive has priority on the shared wire
  assign rxtx_oe = tx_run & s.single_wire_select & ~s.receiver_enable;
  assign rx_irq = s.receiver_interrupt_enable & (s.receive_available_flag | s.overrun_flag);

endmodule : usl_core
`default_nettype wire

// ---- usl_properties.sv ----
// port assertions for the serial status and line control block
`timescale 1ns/1ps
`default_nettype none
module usl_properties
  import usl_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic tx_out,
  input wire logic tx_oe,
  input wire logic rxtx_in,
  input wire logic rxtx_out,
  input wire logic rxtx_oe,
  input wire logic rx_irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [7:0] rx_hi;
  logic [7:0] tx_hi;
  // runs of high line; 200 clocks outlast a 9-bit frame of ones at the minimum bit time
  always_ff @(posedge clk) begin
    rx_hi <= (rst || !rxtx_in) ? 8'h00 : rx_hi + {7'h00, rx_hi != 8'hff};
    tx_hi <= (rst || !tx_out) ? 8'h00 : tx_hi + {7'h00, tx_hi != 8'hff};
  end
  sequence s_rd_status;
    rd && addr == ADDR_STATUS;
  endsequence
  sequence s_tx_ready;
    tx_oe && tx_hi >= 8'hc8;
  endsequence
  sequence s_wr_data;
    wr && addr == ADDR_DATA;
  endsequence
  sequence s_low_bit;
    !tx_out [*8] ##1 !tx_out [*8];
  endsequence
  a_status_reset: assert property ($past(rst) ##0 s_rd_status |=> rdata == STATUS_RESET)
    else $error("status after reset wrong");
  a_wire_mirror: assert property (rxtx_out == tx_out)
    else $error("shared line differs from transmit line");
  a_single_oe: assert property (rxtx_oe |-> tx_oe)
    else $error("shared line driven without transmitter");
  a_disable_float: assert property (wr && addr == ADDR_CTRL_ONE && !wdata[7] |=> ##1 (!tx_oe && !rxtx_oe && !rx_irq))
    else $error("pins or request left active after disable");
  a_bit_low: assert property (disable iff (rst || !tx_oe) $fell(tx_out) |-> s_low_bit)
    else $error("low bit shorter than one bit time");
  a_tx_start: assert property (s_tx_ready ##0 s_wr_data |-> ##[1:4] $fell(tx_out))
    else $error("no start bit after data write");
  a_count_max: assert property (rd && addr == ADDR_RX_COUNT |=> rdata <= 8'h04)
    else $error("receive count above fifo depth");
  a_rx_idle: assert property (rx_hi >= 8'hc8 ##0 s_rd_status |=> rdata[3])
    else $error("receiver not idle on quiet line");
  a_irq_flag: assert property (rx_irq ##0 s_rd_status |=> (rdata[2] || rdata[4]))
    else $error("request without receive flag");
  a_irq_mask: assert property (wr && addr == ADDR_CTRL_TWO && !wdata[2] |=> ##1 !rx_irq)
    else $error("request despite interrupt disable");
endmodule : usl_properties
`default_nettype wire

// ---- usl_partner.sv ----
// far-side serial device: sends frames and captures transmitted ones
`timescale 1ns/1ps
`default_nettype none
module usl_partner (
  input wire logic clk,
  input wire logic tx_out,
  input wire logic [3:0] nbits,
  output logic line,
  output logic [11:0] cap,
  output logic cap_v
);
  localparam int BT = 16;
  initial begin
    line = 1'b1;
    cap = 12'h000;
    cap_v = 1'b0;
  end
  // a bad stop is cut short so the line is back high before the receiver rechecks a start
  task automatic send(input logic [8:0] d, input int n, input logic stop_ok);
    for (int i = 0; i <= n + 1; i++) begin
      line <= (i == 0) ? 1'b0 : (i > n) ? stop_ok : d[i - 1];
      repeat ((i > n && !stop_ok) ? 12 : BT) @(posedge clk);
    end
    line <= 1'b1;
    repeat (2 * BT) @(posedge clk);
  endtask : send
  // captures start, data and both stop bits at mid-bit; nbits of zero means not listening
  always begin
    @(negedge tx_out);
    if (nbits != 4'h0) begin
      cap <= 12'h000;
      repeat (BT / 2) @(posedge clk);
      for (int i = 0; i < int'(nbits) + 3; i++) begin
        cap[i] <= tx_out;
        repeat (BT) @(posedge clk);
      end
      cap_v <= 1'b1;
      @(posedge clk);
      cap_v <= 1'b0;
    end
  end
endmodule : usl_partner
`default_nettype wire

// ---- usl_core_tb.sv ----
// self-checking bench for the serial status and line control block
`timescale 1ns/1ps
`default_nettype none
module usl_core_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] addr = 3'h0;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic [7:0] rdata;
  logic tx_out, tx_oe, rxtx_out, rxtx_oe, rx_irq, p_line, cap_v, par;
  logic [3:0] nbits = 4'h0;
  logic [11:0] cap;
  logic [7:0] d, b[5];
  logic [15:0] rq[$];
  logic [11:0] sq[$];
  int n_fail = 0;
  int comparisons = 0;
  int seed = 32'hf4fc;
  wire rxtx_in = rxtx_oe ? rxtx_out : p_line;
  always #5 clk = ~clk;
  usl_core usl_core_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .tx_out(tx_out), .tx_oe(tx_oe), .rxtx_in(rxtx_in), .rxtx_out(rxtx_out), .rxtx_oe(rxtx_oe), .rx_irq(rx_irq));
  usl_partner usl_partner_i (.clk(clk), .tx_out(tx_out), .nbits(nbits), .line(p_line), .cap(cap), .cap_v(cap_v));
  task automatic chk(input logic [11:0] s, input logic [11:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic pin(ref logic s, input logic e);
    #1;
    chk({11'h000, s}, {11'h000, e});
    @(posedge clk);
  endtask : pin
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic wreg(input logic [2:0] a, input logic [7:0] v);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wreg
  task automatic rreg(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    addr <= a;
    rd <= 1'b1;
    rq.push_back({m, e});
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask : rreg
  task automatic finish_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test
  always @(posedge clk) begin
    rd_d <= rd;
  end
  // read data stand only in the cycle after the strobe; taken mid-cycle, away from the edge that replaces them
  always @(negedge clk) begin
    if (rd_d) begin
      chk({4'h0, rdata & rq[0][15:8]}, {4'h0, rq[0][7:0]});
      void'(rq.pop_front());
    end
    if (cap_v) begin
      chk(cap, sq.pop_front());
    end
  end
  initial begin
    cyc(12);
    rst <= 1'b0;
    rreg(3'h0, 8'h0b);
    wreg(3'h0, 8'hf4);
    rreg(3'h0, 8'h0b);
    wreg(3'h1, 8'h80);
    wreg(3'h2, 8'hc4);
    rreg(3'h0, 8'h0b);
    pin(tx_oe, 1'b1);
    for (int p = 0; p < 5; p++) begin
      d = 8'($random(seed));
      par = p[1] ? ~p[0] : ^d[6:0] ^ p[0];
      wreg(3'h1, {2'b10, p < 4, p[1:0], 3'h0});
      nbits <= 4'h8;
      sq.push_back({3'b011, (p < 4) ? {par, d[6:0]} : d, 1'b0});
      rreg(3'h0, 8'h0b);
      wreg(3'h4, d);
      cyc(10);
      rreg(3'h0, 8'h09);
      cyc(190);
      rreg(3'h0, 8'h0b);
    end
    d = 8'($random(seed));
    wreg(3'h1, 8'hc1);
    nbits <= 4'h9;
    sq.push_back({2'b11, 1'b1, d, 1'b0});
    rreg(3'h0, 8'h0b);
    wreg(3'h4, d);
    cyc(220);
    rreg(3'h1, 8'hc0);
    usl_partner_i.send({1'b1, d}, 9, 1'b1);
    rreg(3'h1, 8'hc2);
    rreg(3'h0, 8'h0f);
    rreg(3'h4, d);
    rreg(3'h0, 8'h0b);
    wreg(3'h1, 8'h80);
    d = 8'($random(seed));
    fork
      usl_partner_i.send({1'b0, d}, 8, 1'b1);
      begin
        cyc(40);
        rreg(3'h0, 8'h03);
      end
    join
    rreg(3'h0, 8'h0f);
    rreg(3'h4, d);
    rreg(3'h0, 8'h0b);
    wreg(3'h2, 8'he4);
    usl_partner_i.send({1'b0, d}, 8, 1'b0);
    rreg(3'h0, 8'h2f);
    rreg(3'h4, d);
    rreg(3'h0, 8'h0b);
    wreg(3'h1, 8'ha0);
    usl_partner_i.send({1'b0, ~^d[6:0], d[6:0]}, 8, 1'b1);
    rreg(3'h0, 8'h8f);
    rreg(3'h4, {1'b0, d[6:0]});
    rreg(3'h0, 8'h0b);
    wreg(3'h1, 8'h80);
    for (int i = 0; i < 5; i++) begin
      b[i] = 8'($random(seed));
      usl_partner_i.send({1'b0, b[i]}, 8, 1'b1);
    end
    rreg(3'h7, 8'h04);
    rreg(3'h0, 8'h1f);
    pin(rx_irq, 1'b1);
    wreg(3'h2, 8'hc0);
    cyc(1);
    pin(rx_irq, 1'b0);
    wreg(3'h2, 8'hc4);
    rreg(3'h4, b[0]);
    for (int i = 1; i < 4; i++) begin
      rreg(3'h0, 8'h0f);
      rreg(3'h4, b[i]);
    end
    rreg(3'h0, 8'h0b);
    nbits <= 4'h8;
    sq.push_back(12'h000);
    wreg(3'h1, 8'h84);
    cyc(13 * 16);
    pin(tx_out, 1'b0);
    wreg(3'h1, 8'h80);
    cyc(40);
    pin(tx_out, 1'b1);
    nbits <= 4'h0;
    wreg(3'h1, 8'hc0);
    rreg(3'h0, 8'h0b);
    wreg(3'h4, 8'h55);
    cyc(50);
    wreg(3'h1, 8'h40);
    cyc(2);
    rreg(3'h0, 8'h0b);
    rreg(3'h2, 8'h04);
    rreg(3'h1, 8'h40);
    pin(tx_oe, 1'b0);
    pin(tx_out, 1'b1);
    wreg(3'h1, 8'hc0);
    rreg(3'h1, 8'hc0);
    wreg(3'h3, 8'h01);
    wreg(3'h2, 8'hc0);
    pin(rxtx_oe, 1'b0);
    wreg(3'h2, 8'h80);
    pin(rxtx_oe, 1'b1);
    pin(rxtx_out, 1'b1);
    rreg(3'h3, 8'h01);
    wreg(3'h6, 8'h20);
    rreg(3'h6, 8'h20);
    cyc(4);
    finish_test();
  end
  initial begin
    cyc(20000);
    n_fail++;
    $display("[ERR] %0t run did not finish", $time);
    finish_test();
  end
endmodule : usl_core_tb
bind usl_core usl_properties usl_properties_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
  .rd(rd), .rdata(rdata), .tx_out(tx_out), .tx_oe(tx_oe), .rxtx_in(rxtx_in), .rxtx_out(rxtx_out),
  .rxtx_oe(rxtx_oe), .rx_irq(rx_irq));
`default_nettype wire
